/* File: pmd_chk.sv */
// Concurrent checks on the CPU, DRAM and ROM side of the controller.
module pmd_chk (
    input wire logic        clk,
    input wire logic        rst_n,
    input wire logic [23:1] cpuAddr,
    input wire logic        refreshReqN,
    input wire logic [3:0]  bankRowStrobeN,
    input wire logic        colStrobeN,
    input wire logic        bufferedMemRdN,
    input wire logic        onboardReadyN,
    input wire logic        nextAddrReqN,
    input wire logic        romSelectN,
    input wire logic        romOutputEnN,
    input wire logic        addrLatchStrobe,
    input wire logic [9:0]  dramAddr
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence readyPulse;
        !onboardReadyN [*2] ##1 onboardReadyN;
    endsequence
    a_ready_two: assert property ($fell(onboardReadyN) |-> readyPulse)
        else $error("ready pulse width wrong");
    sequence casAfterMux;
        colStrobeN ##1 colStrobeN ##1 !colStrobeN;
    endsequence
    a_ras_cas: assert property ($fell(bankRowStrobeN[0]) && refreshReqN |-> casAfterMux)
        else $error("row to column strobe spacing wrong");
    a_na_ready: assert property (nextAddrReqN == onboardReadyN)
        else $error("next address request differs from ready");
    a_ale_two: assert property ($rose(addrLatchStrobe) |=> addrLatchStrobe ##1 !addrLatchStrobe)
        else $error("address latch strobe width wrong");
    a_hit_read: assert property ($fell(addrLatchStrobe) && !onboardReadyN |-> !colStrobeN && !bufferedMemRdN)
        else $error("hit read column strobe late");
    a_rom_oe: assert property (!romOutputEnN |-> !romSelectN)
        else $error("rom output enable without select");
    a_rom_wait: assert property ($fell(addrLatchStrobe) && !romSelectN |-> onboardReadyN [*4] ##1 readyPulse)
        else $error("rom wait states wrong");
    a_ref_cas: assert property (bankRowStrobeN == 4'h0 && !refreshReqN |-> colStrobeN && dramAddr == cpuAddr[10:1])
        else $error("refresh strobes or address wrong");
    // Refresh also lifts the row strobes, so only quiet refresh history counts as a page miss.
    a_miss_pre: assert property ($rose(bankRowStrobeN[0]) && refreshReqN && $past(refreshReqN) && $past(refreshReqN, 2)
        |-> bankRowStrobeN[0] [*3] ##1 !bankRowStrobeN[0])
        else $error("precharge time wrong");
endmodule

bind pmd_controller pmd_chk chk_u (.clk(clk), .rst_n(rst_n), .cpuAddr(cpuAddr), .refreshReqN(refreshReqN),
    .bankRowStrobeN(bankRowStrobeN), .colStrobeN(colStrobeN), .bufferedMemRdN(bufferedMemRdN),
    .onboardReadyN(onboardReadyN), .nextAddrReqN(nextAddrReqN), .romSelectN(romSelectN),
    .romOutputEnN(romOutputEnN), .addrLatchStrobe(addrLatchStrobe), .dramAddr(dramAddr));

/* File: pmd_controller.sv */
// Page-mode DRAM and boot ROM controller with its Wishbone strap and status registers.
module pmd_controller (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [3:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic [23:1] cpuAddr,
    input  wire logic        addrStrobeN,
    input  wire logic        memIoSel,
    input  wire logic        dataCtrlSel,
    input  wire logic        writeRead,
    input  wire logic        refreshReqN,
    input  wire logic        cpuPhaseClock,
    output logic      [3:0]  bankRowStrobeN,
    output logic             colStrobeN,
    output logic             bufferedMemRdN,
    output logic             bufferedMemWrN,
    output logic             onboardReadyN,
    output logic             nextAddrReqN,
    output logic      [1:0]  offboardStatus,
    output logic             romSelectN,
    output logic             romOutputEnN,
    output logic             addrLatchStrobe,
    output logic      [9:0]  dramAddr
);
    typedef struct packed {
        pmd_pkg::pmd_state_e st;
        logic [2:0]          cnt;
        logic [1:0]          waits;
        logic [8:0]          ctrl;
        logic                wbAck;
        logic [31:0]         wbDat;
        logic [3:0]          rasN;
        logic                casN;
        logic                bmrN;
        logic                bmwN;
        logic [1:0]          sts;
        logic                romCsN;
        logic                romOeN;
        logic                ale;
        logic                muxCol;
        logic [9:0]          maddr;
        logic [9:0]          col;
        logic [12:0]         tag;
        logic [1:0]          bank;
        logic                isWrite;
        logic                isDram;
        logic                lastHit;
        logic                phA;
        logic                phB;
    } pmd_ctl_s;

    pmd_ctl_s r;
    pmd_ctl_s n;

    logic [3:0]  bankCfgSel;
    logic        remapDisableN;
    logic        pageSizeSel;
    logic        waitSelA;
    logic        waitSelB;
    logic        shadowEnableN;
    logic [23:0] byteAddr;
    logic [23:0] physAddr;
    logic [24:0] topAddr;
    logic [24:0] remapEnd;
    logic [3:0]  belowEnd;
    logic [1:0]  bankIdx;
    logic [1:0]  dramBank;
    logic        belowTop;
    logic        inHole;
    logic        inRomLo;
    logic        inRomHi;
    logic        remapHit;
    logic        shadowHit;
    logic        memAccess;
    logic        goDram;
    logic        goRom;
    logic [2:0]  cycCode;
    logic [1:0]  missWaits;
    logic [9:0]  rowAddr;
    logic [9:0]  colAddr;
    logic [12:0] rowTag;
    logic [12:0] memTag;
    logic        tagMatch;
    logic        refreshing;

    assign bankCfgSel    = r.ctrl[pmd_pkg::CTRL_CFG_LSB +: 4];
    assign remapDisableN = r.ctrl[pmd_pkg::CTRL_REMAP_BIT];
    assign pageSizeSel   = r.ctrl[pmd_pkg::CTRL_PAGE_BIT];
    assign waitSelA      = r.ctrl[pmd_pkg::CTRL_WSA_BIT];
    assign waitSelB      = r.ctrl[pmd_pkg::CTRL_WSB_BIT];
    assign shadowEnableN = r.ctrl[pmd_pkg::CTRL_SHADOW_BIT];

    assign byteAddr   = {cpuAddr, 1'b0};
    assign cycCode    = {memIoSel, dataCtrlSel, writeRead};
    assign refreshing = (r.st == pmd_pkg::ST_RPRE) || (r.st == pmd_pkg::ST_REF);

    // Each bank covers the space from the previous bank's end up to its own end.
    genvar g;
    generate
        for (g = 0; g < 4; g++) begin : gBank
            assign belowEnd[g] = {1'b0, byteAddr} < {pmd_pkg::pmd_bank_end(bankCfgSel, 2'(g)), 20'h00000};
        end
    endgenerate

    always_comb begin
        topAddr  = {pmd_pkg::pmd_bank_end(bankCfgSel, bankCfgSel[1:0]), 20'h00000};
        remapEnd = topAddr + {1'b0, pmd_pkg::REMAP_SPAN};
        belowTop = belowEnd[bankCfgSel[1:0]];
        if (belowEnd[0]) begin
            bankIdx = 2'h0;
        end else if (belowEnd[1]) begin
            bankIdx = 2'h1;
        end else if (belowEnd[2]) begin
            bankIdx = 2'h2;
        end else begin
            bankIdx = 2'h3;
        end
        inHole  = (byteAddr >= pmd_pkg::ADDR_640K) && (byteAddr < pmd_pkg::ADDR_1M);
        inRomLo = byteAddr[23:17] == pmd_pkg::ROM_LO_BASE[23:17];
        inRomHi = byteAddr[23:17] == pmd_pkg::ROM_HI_BASE[23:17];
        remapHit = remapDisableN && ({1'b0, byteAddr} >= topAddr) && ({1'b0, byteAddr} < remapEnd);
        // Writes into the low ROM window always land in DRAM so the shadow copy can be made.
        shadowHit = inRomLo && (writeRead || !shadowEnableN);
        memAccess = memIoSel && (cycCode != pmd_pkg::CYC_HALT);
        goDram = memAccess && !inRomHi && ((belowTop && !inHole) || remapHit || shadowHit);
        goRom  = memAccess && (inRomLo || inRomHi) && !goDram;
        dramBank = (remapHit || shadowHit) ? 2'h0 : bankIdx;
        if (remapHit) begin
            physAddr = byteAddr - topAddr[23:0] + pmd_pkg::ADDR_640K;
        end else begin
            physAddr = byteAddr;
        end
        rowTag = physAddr[23:11];
        // Row bits pass from the CPU bus; the column comes from the copy taken at ALE fall.
        if (refreshing) begin
            rowAddr = cpuAddr[10:1];
        end else if (pageSizeSel) begin
            rowAddr = physAddr[20:11];
        end else begin
            rowAddr = physAddr[21:12];
        end
        colAddr = pageSizeSel ? {cpuAddr[1], physAddr[10:2]} : physAddr[11:2];
        if (pageSizeSel) begin
            tagMatch = memTag == r.tag;
        end else begin
            tagMatch = memTag[12:1] == r.tag[12:1];
        end
        if (waitSelA && waitSelB) begin
            missWaits = pmd_pkg::MISS_WAITS_FAST;
        end else if (waitSelA && r.isWrite) begin
            missWaits = pmd_pkg::MISS_WAITS_FAST;
        end else begin
            missWaits = pmd_pkg::MISS_WAITS_SLOW;
        end
    end

    pmd_row_mem uRowMem (
        .clk   (clk),
        .rst_n (rst_n),
        .rdIdx (r.bank),
        .wrEn  (r.st == pmd_pkg::ST_RAS),
        .wrIdx (r.bank),
        .wrTag (r.tag),
        .rdTag (memTag)
    );

    always_comb begin
        n = r;
        // The phase clock is a pin, so it is synchronised before the sequencer looks at it.
        n.phA = cpuPhaseClock;
        n.phB = r.phA;

        // Register bus: ack one cycle after the request, a write lands on the ack edge.
        n.wbAck = wb_cyc_i && wb_stb_i && !r.wbAck;
        n.wbDat = 32'h0000_0000;
        if (wb_adr_i == pmd_pkg::WB_CTRL_OFS) begin
            n.wbDat[8:0] = r.ctrl;
        end else if (wb_adr_i == pmd_pkg::WB_STAT_OFS) begin
            n.wbDat[pmd_pkg::STAT_OPEN_LSB +: 4]  = ~r.rasN;
            n.wbDat[pmd_pkg::STAT_STATE_LSB +: 4] = r.st;
            n.wbDat[pmd_pkg::STAT_HIT_BIT]        = r.lastHit;
            n.wbDat[pmd_pkg::STAT_REF_BIT]        = refreshing;
        end
        if (wb_cyc_i && wb_stb_i && wb_we_i && r.wbAck && wb_adr_i == pmd_pkg::WB_CTRL_OFS) begin
            if (wb_sel_i[0]) begin
                n.ctrl[7:0] = wb_dat_i[7:0];
            end
            if (wb_sel_i[1]) begin
                n.ctrl[8] = wb_dat_i[8];
            end
        end

        case (r.st)
            pmd_pkg::ST_IDLE: begin
                n.casN   = 1'b1;
                n.bmrN   = 1'b1;
                n.bmwN   = 1'b1;
                n.romCsN = 1'b1;
                n.romOeN = 1'b1;
                n.sts    = pmd_pkg::STS_IDLE;
                n.muxCol = 1'b0;
                n.cnt    = 3'h0;
                // Refresh wins over a new cycle and ignores whatever the bus is doing.
                if (!refreshReqN) begin
                    n.rasN = 4'hF;
                    n.st   = pmd_pkg::ST_RPRE;
                end else if (!addrStrobeN && r.phB && cycCode != 3'h1) begin
                    n.ale     = 1'b1;
                    n.st      = pmd_pkg::ST_ALE;
                    n.isWrite = writeRead;
                    n.isDram  = goDram;
                    n.bank    = dramBank;
                    n.tag     = rowTag;
                    n.romCsN  = !goRom;
                    if (!goDram && !goRom) begin
                        case (cycCode)
                            pmd_pkg::CYC_INTA:    n.sts = pmd_pkg::STS_ACK;
                            pmd_pkg::CYC_HALT:    n.sts = pmd_pkg::STS_ACK;
                            pmd_pkg::CYC_IO_RD:   n.sts = pmd_pkg::STS_READ;
                            pmd_pkg::CYC_IO_WR:   n.sts = pmd_pkg::STS_WRITE;
                            pmd_pkg::CYC_CODE_RD: n.sts = pmd_pkg::STS_READ;
                            pmd_pkg::CYC_DATA_RD: n.sts = pmd_pkg::STS_READ;
                            default:              n.sts = pmd_pkg::STS_WRITE;
                        endcase
                    end
                end
            end
            pmd_pkg::ST_ALE: begin
                n.cnt = r.cnt + 3'h1;
                if (r.cnt == pmd_pkg::ALE_CLKS - 3'h1) begin
                    n.ale = 1'b0;
                    n.cnt = 3'h0;
                    n.col = colAddr;
                    n.sts = pmd_pkg::STS_IDLE;
                    if (r.isDram) begin
                        n.bmrN = r.isWrite;
                        n.bmwN = !r.isWrite;
                        n.lastHit = !r.rasN[r.bank] && tagMatch;
                        if (!r.rasN[r.bank] && tagMatch) begin
                            n.muxCol = 1'b1;
                            if (r.isWrite) begin
                                n.st = pmd_pkg::ST_HOLD;
                            end else begin
                                n.casN = 1'b0;
                                n.st   = pmd_pkg::ST_RDY;
                            end
                        end else if (!r.rasN[r.bank]) begin
                            n.rasN[r.bank] = 1'b1;
                            n.st           = pmd_pkg::ST_PRE;
                        end else begin
                            n.rasN[r.bank] = 1'b0;
                            n.waits        = pmd_pkg::FIRST_WAITS;
                            n.st           = pmd_pkg::ST_RAS;
                        end
                    end else if (!r.romCsN) begin
                        n.romOeN = r.isWrite;
                        n.waits  = pmd_pkg::ROM_WAITS;
                        n.st     = pmd_pkg::ST_WAIT;
                    end else begin
                        n.st = pmd_pkg::ST_IDLE;
                    end
                end
            end
            pmd_pkg::ST_HOLD: begin
                // A page-hit write waits one phase-clock period before the column strobe.
                n.cnt = r.cnt + 3'h1;
                if (r.cnt == pmd_pkg::PHASE_CLKS - 3'h1) begin
                    n.cnt  = 3'h0;
                    n.casN = 1'b0;
                    n.st   = pmd_pkg::ST_RDY;
                end
            end
            pmd_pkg::ST_PRE: begin
                n.cnt = r.cnt + 3'h1;
                if (r.cnt == pmd_pkg::PRECHARGE_CLKS - 3'h1) begin
                    n.cnt          = 3'h0;
                    n.rasN[r.bank] = 1'b0;
                    n.waits        = missWaits;
                    n.st           = pmd_pkg::ST_RAS;
                end
            end
            pmd_pkg::ST_RAS: begin
                n.muxCol = 1'b1;
                n.st     = pmd_pkg::ST_MUX;
            end
            pmd_pkg::ST_MUX: begin
                n.casN = 1'b0;
                n.st   = pmd_pkg::ST_WAIT;
            end
            pmd_pkg::ST_WAIT: begin
                n.cnt = r.cnt + 3'h1;
                if ({1'b0, r.cnt} + 4'h1 >= {1'b0, r.waits, 1'b0}) begin
                    n.cnt = 3'h0;
                    n.st  = pmd_pkg::ST_RDY;
                end
            end
            pmd_pkg::ST_RDY: begin
                n.cnt = r.cnt + 3'h1;
                if (r.cnt == pmd_pkg::PHASE_CLKS - 3'h1) begin
                    // The row strobe is left low so the next access can hit the open page.
                    n.cnt    = 3'h0;
                    n.casN   = 1'b1;
                    n.bmrN   = 1'b1;
                    n.bmwN   = 1'b1;
                    n.romCsN = 1'b1;
                    n.romOeN = 1'b1;
                    n.st     = pmd_pkg::ST_IDLE;
                end
            end
            pmd_pkg::ST_RPRE: begin
                n.cnt = r.cnt + 3'h1;
                if (r.cnt == pmd_pkg::PRECHARGE_CLKS - 3'h1) begin
                    n.cnt  = 3'h0;
                    n.rasN = 4'h0;
                    n.st   = pmd_pkg::ST_REF;
                end
            end
            pmd_pkg::ST_REF: begin
                // Refresh destroys every open page, so all banks come back closed.
                if (refreshReqN) begin
                    n.rasN = 4'hF;
                    n.st   = pmd_pkg::ST_IDLE;
                end
            end
            default: begin
                n.st = pmd_pkg::ST_IDLE;
            end
        endcase
        // The pins follow the new mux select, so a hit's column stands when its column strobe falls.
        n.maddr = n.muxCol ? n.col : rowAddr;
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r         <= '0;
            r.st      <= pmd_pkg::ST_IDLE;
            r.ctrl    <= pmd_pkg::CTRL_RESET;
            r.rasN    <= 4'hF;
            r.casN    <= 1'b1;
            r.bmrN    <= 1'b1;
            r.bmwN    <= 1'b1;
            r.sts     <= pmd_pkg::STS_IDLE;
            r.romCsN  <= 1'b1;
            r.romOeN  <= 1'b1;
        end else begin
            r <= n;
        end
    end

    assign wb_dat_o        = r.wbDat;
    assign wb_ack_o        = r.wbAck;
    assign bankRowStrobeN  = r.rasN;
    assign colStrobeN      = r.casN;
    assign bufferedMemRdN  = r.bmrN;
    assign bufferedMemWrN  = r.bmwN;
    assign onboardReadyN   = !(r.st == pmd_pkg::ST_RDY);
    assign nextAddrReqN    = !(r.st == pmd_pkg::ST_RDY);
    assign offboardStatus  = r.sts;
    assign romSelectN      = r.romCsN;
    assign romOutputEnN    = r.romOeN;
    assign addrLatchStrobe = r.ale;
    assign dramAddr        = r.maddr;
endmodule

/* File: pmd_cpu_model.sv */
// Processor-side partner that makes the phase clock pacing the bus cycles.
module pmd_cpu_model (
    input  wire logic clk,
    output logic      cpuPhaseClock
);
    timeunit 1ns;
    timeprecision 1ps;
    initial cpuPhaseClock = 1'b0;
    always @(posedge clk) cpuPhaseClock <= ~cpuPhaseClock;
endmodule

/* File: pmd_pkg.sv */
// Constants, types and the bank table of the page-mode DRAM and boot ROM controller.
package pmd_pkg;
    localparam logic [3:0]  WB_CTRL_OFS     = 4'h0;
    localparam logic [3:0]  WB_STAT_OFS     = 4'h4;
    localparam int          CTRL_CFG_LSB    = 0;
    localparam int          CTRL_REMAP_BIT  = 4;
    localparam int          CTRL_PAGE_BIT   = 5;
    localparam int          CTRL_WSA_BIT    = 6;
    localparam int          CTRL_WSB_BIT    = 7;
    localparam int          CTRL_SHADOW_BIT = 8;
    localparam logic [8:0]  CTRL_RESET      = 9'h130;
    localparam int          STAT_OPEN_LSB   = 0;
    localparam int          STAT_STATE_LSB  = 4;
    localparam int          STAT_HIT_BIT    = 8;
    localparam int          STAT_REF_BIT    = 9;

    localparam logic [23:0] ADDR_640K       = 24'h0A0000;
    localparam logic [23:0] ADDR_1M         = 24'h100000;
    localparam logic [23:0] REMAP_SPAN      = 24'h060000;
    localparam logic [23:0] ROM_LO_BASE     = 24'h0E0000;
    localparam logic [23:0] ROM_HI_BASE     = 24'hFE0000;

    localparam logic [2:0]  CYC_INTA        = 3'h0;
    localparam logic [2:0]  CYC_IO_RD       = 3'h2;
    localparam logic [2:0]  CYC_IO_WR       = 3'h3;
    localparam logic [2:0]  CYC_CODE_RD     = 3'h4;
    localparam logic [2:0]  CYC_HALT        = 3'h5;
    localparam logic [2:0]  CYC_DATA_RD     = 3'h6;
    localparam logic [2:0]  CYC_DATA_WR     = 3'h7;

    localparam logic [1:0]  STS_IDLE        = 2'h3;
    localparam logic [1:0]  STS_READ        = 2'h2;
    localparam logic [1:0]  STS_WRITE       = 2'h1;
    localparam logic [1:0]  STS_ACK         = 2'h0;

    localparam logic [2:0]  ALE_CLKS        = 3'h2;
    localparam logic [2:0]  PHASE_CLKS      = 3'h2;
    localparam logic [2:0]  PRECHARGE_CLKS  = 3'h3;
    localparam logic [1:0]  FIRST_WAITS     = 2'h1;
    localparam logic [1:0]  ROM_WAITS       = 2'h2;
    localparam logic [1:0]  MISS_WAITS_SLOW = 2'h2;
    localparam logic [1:0]  MISS_WAITS_FAST = 2'h1;

    // Bank end addresses in megabytes, bank 0 in the lowest slot.
    localparam logic [3:0][4:0] BANK_END_256K = {5'h04, 5'h03, 5'h02, 5'h01};
    localparam logic [3:0][4:0] BANK_END_MIX  = {5'h0A, 5'h06, 5'h02, 5'h01};
    localparam logic [3:0][4:0] BANK_END_1M   = {5'h10, 5'h0C, 5'h08, 5'h04};

    typedef enum logic [3:0] {
        ST_IDLE = 4'h0,
        ST_ALE  = 4'h1,
        ST_HOLD = 4'h2,
        ST_PRE  = 4'h3,
        ST_RAS  = 4'h4,
        ST_MUX  = 4'h5,
        ST_WAIT = 4'h6,
        ST_RDY  = 4'h7,
        ST_RPRE = 4'h8,
        ST_REF  = 4'h9
    } pmd_state_e;

    // The unlisted type code 10 decodes like the all-1M layout.
    function automatic logic [4:0] pmd_bank_end(input logic [3:0] cfg, input logic [1:0] idx);
        case (cfg[3:2])
            2'h0:    return BANK_END_256K[idx];
            2'h1:    return BANK_END_MIX[idx];
            default: return BANK_END_1M[idx];
        endcase
    endfunction
endpackage

/* File: pmd_row_mem.sv */
// Four-entry open-row tag memory with a registered read port.
module pmd_row_mem (
    input  wire logic        clk,
    input  wire logic        rst_n,
    input  wire logic [1:0]  rdIdx,
    input  wire logic        wrEn,
    input  wire logic [1:0]  wrIdx,
    input  wire logic [12:0] wrTag,
    output logic      [12:0] rdTag
);
    typedef struct packed {
        logic [3:0][12:0] rows;
        logic [12:0]      rd;
    } pmd_mem_s;

    pmd_mem_s r;
    pmd_mem_s n;

    always_comb begin
        n = r;
        n.rd = r.rows[rdIdx];
        if (wrEn) begin
            n.rows[wrIdx] = wrTag;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            r <= '0;
        end else begin
            r <= n;
        end
    end

    assign rdTag = r.rd;
endmodule

/* File: tb.sv */
// Directed bench for the page-mode DRAM and boot ROM controller.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic        wbCyc = 1'b0;
    logic        wbStb = 1'b0;
    logic        wbWe = 1'b0;
    logic [3:0]  wbAdr = 4'h0;
    logic [31:0] wbDatI = 32'h0;
    logic [23:1] cpuAddr = 23'h0;
    logic        asN = 1'b1;
    logic        refN = 1'b1;
    logic [2:0]  code = 3'h0;
    logic [4:0]  seenN = 5'h1F;
    logic [31:0] wbDatO, q;
    logic [3:0]  rasN;
    logic [9:0]  ma;
    logic [1:0]  sts, st;
    logic        wbAck, phase, casN, rdN, wrN, rdyN, romN, oeN, ale;
    int          failures = 0, numChecks = 0, cycles = 0, lat;
    logic [8:0]  ctrlTab [3] = '{9'h130, 9'h170, 9'h1F0};
    int          rdWs [3] = '{2, 2, 1};
    int          wrWs [3] = '{2, 1, 1};
    logic [2:0]  codeTab [5] = '{pmd_pkg::CYC_IO_RD, pmd_pkg::CYC_IO_WR, pmd_pkg::CYC_INTA, pmd_pkg::CYC_HALT,
                                 pmd_pkg::CYC_DATA_RD};
    logic [1:0]  stsTab [5] = '{pmd_pkg::STS_READ, pmd_pkg::STS_WRITE, pmd_pkg::STS_ACK, pmd_pkg::STS_ACK,
                                pmd_pkg::STS_READ};

    pmd_controller dut_u (.clk(clk), .rst_n(rst_n), .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_we_i(wbWe),
        .wb_adr_i(wbAdr), .wb_sel_i(4'hF), .wb_dat_i(wbDatI), .wb_dat_o(wbDatO), .wb_ack_o(wbAck),
        .cpuAddr(cpuAddr), .addrStrobeN(asN), .memIoSel(code[2]), .dataCtrlSel(code[1]), .writeRead(code[0]),
        .refreshReqN(refN), .cpuPhaseClock(phase), .bankRowStrobeN(rasN), .colStrobeN(casN),
        .bufferedMemRdN(rdN), .bufferedMemWrN(wrN), .onboardReadyN(rdyN), .nextAddrReqN(),
        .offboardStatus(sts), .romSelectN(romN), .romOutputEnN(oeN), .addrLatchStrobe(ale), .dramAddr(ma));
    pmd_cpu_model cpu_u (.clk(clk), .cpuPhaseClock(phase));

    always #5 clk = ~clk;
    // Collects which strobes went low during one CPU cycle: rom, oe, read, write, cas.
    always @(negedge clk) seenN <= seenN & {romN, oeN, rdN, wrN, casN};
    always @(posedge clk) begin
        cycles++;
        if (cycles > 20000) begin
            failures++;
            stop_test();
        end
    end

    task automatic stop_test();
        $display("checks %0d failures %0d", numChecks, failures);
        if (failures == 0 && numChecks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        numChecks++;
        if (got !== exp) begin
            $display("ERROR %s expected %h seen %h", nm, exp, got);
            failures++;
        end
    endtask

    task automatic doReset();
        @(posedge clk);
        rst_n <= 1'b0;
        repeat (20) @(posedge clk);
        rst_n <= 1'b1;
    endtask

    task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        wbCyc <= 1'b1;
        wbStb <= 1'b1;
        wbWe <= w;
        wbAdr <= a;
        wbDatI <= d;
        do begin
            @(posedge clk);
        end while (wbAck !== 1'b1);
        q = wbDatO;
        wbCyc <= 1'b0;
        wbStb <= 1'b0;
    endtask

    // Latency is counted in clocks from the fall of the address latch strobe to ready; 20 means none came.
    task automatic cpu(input logic [23:0] a, input logic [2:0] c);
        int n = 0;
        @(posedge clk);
        cpuAddr <= a[23:1];
        code <= c;
        asN <= 1'b0;
        seenN = 5'h1F;
        do begin
            @(negedge clk);
            n++;
        end while (ale !== 1'b1 && n < 20);
        st = sts;
        while (ale === 1'b1 && n < 20) @(negedge clk);
        lat = 0;
        while (rdyN !== 1'b0 && lat < 20) begin
            @(posedge clk);
            asN <= 1'b1;
            @(negedge clk);
            lat++;
        end
        @(posedge clk);
        asN <= 1'b1;
        while (rdyN === 1'b0) @(negedge clk);
    endtask

    initial begin
        doReset();
        wb(1'b0, 4'h0, 32'h0);
        chk("ctrl reset", 32'h130, q);
        wb(1'b1, 4'h8, 32'hFF);
        wb(1'b0, 4'h8, 32'h0);
        chk("unmapped", 32'h0, q);
        cpu(24'h000100, pmd_pkg::CYC_DATA_RD);
        chk("first latency", 32'h4, lat);
        chk("first strobes", 32'h1A, {27'h0, seenN});
        cpu(24'h000200, pmd_pkg::CYC_DATA_RD);
        chk("hit read latency", 32'h0, lat);
        cpu(24'h000300, pmd_pkg::CYC_DATA_WR);
        chk("hit write latency", 32'h2, lat);
        chk("hit write strobes", 32'h1C, {27'h0, seenN});
        for (int i = 0; i < 3; i++) begin
            wb(1'b1, 4'h0, {23'h0, ctrlTab[i]});
            cpu(24'h010000 + 24'h001000 * i, pmd_pkg::CYC_DATA_RD);
            chk("miss read latency", 5 + 2 * rdWs[i], lat);
            cpu(24'h010800 + 24'h001000 * i, pmd_pkg::CYC_DATA_WR);
            chk("miss write latency", 5 + 2 * wrWs[i], lat);
        end
        wb(1'b1, 4'h0, 32'h1D0);
        cpu(24'h020000, pmd_pkg::CYC_DATA_RD);
        cpu(24'h020800, pmd_pkg::CYC_DATA_RD);
        chk("large page hit", 32'h0, lat);
        wb(1'b1, 4'h0, 32'h1F0);
        cpu(24'h021000, pmd_pkg::CYC_DATA_RD);
        cpu(24'h021800, pmd_pkg::CYC_DATA_RD);
        chk("small page miss", 32'h7, lat);
        cpu(24'h0E0000, pmd_pkg::CYC_DATA_RD);
        chk("low rom latency", 32'h4, lat);
        chk("low rom strobes", 32'h07, {27'h0, seenN});
        cpu(24'hFE0000, pmd_pkg::CYC_CODE_RD);
        chk("high rom strobes", 32'h07, {27'h0, seenN});
        wb(1'b1, 4'h0, 32'h0F0);
        cpu(24'h0E0000, pmd_pkg::CYC_DATA_RD);
        chk("shadow read strobes", 32'h1A, {27'h0, seenN});
        for (int i = 0; i < 5; i++) begin
            cpu((i == 4) ? 24'h800000 : 24'h000400, codeTab[i]);
            chk("offboard status", {30'h0, stsTab[i]}, {30'h0, st});
            chk("offboard no ready", 32'd20, lat);
        end
        @(posedge clk);
        cpuAddr <= 23'h000155;
        refN <= 1'b0;
        lat = 0;
        while (rasN !== 4'h0 && lat < 20) begin
            @(negedge clk);
            lat++;
        end
        chk("refresh pins", {17'h0, 4'h0, 1'b1, 10'h155}, {17'h0, rasN, casN, ma});
        @(posedge clk);
        refN <= 1'b1;
        repeat (4) @(posedge clk);
        cpu(24'h000100, pmd_pkg::CYC_DATA_RD);
        chk("after refresh latency", 32'h4, lat);
        cpu(24'h000100, pmd_pkg::CYC_DATA_RD);
        wb(1'b0, 4'h4, 32'h0);
        chk("status open hit", 32'h101, q);
        doReset();
        cpu(24'h000100, pmd_pkg::CYC_DATA_RD);
        chk("after reset latency", 32'h4, lat);
        stop_test();
    end
endmodule
